// *** cam_top.sv ***
// Counter array top: APB registers, main counter, flags and module instances.
// Operation
// - Cycle overflow flag interrupts when its enable set.
// - Cycle overflow flag set at selected bit overflow.
// - Cycle overflow flag cleared only by software.
// - Configuration bit 4 reads zero, ignores writes.
// - Wide PWM reloads compare value on overflow.
// - Wide select picks 16-bit or 8-15 bit PWM.
// - Compare runs only with compare enable set.
// - Rising edge captures counter when enabled.
// - Falling edge captures counter when enabled.
// - Match sets module flag when match enabled.
// - Match toggles output pin when toggle enabled.
// - Toggle plus PWM gives frequency output.
// - PWM enable drives modulated output pin.
// - Flag interrupt enable gates module flag interrupt.
// - Watchdog enable locks module 2 mode register.
// - Bank select routes value accesses to reload.
// - Low value byte write clears compare enable.
// - High value byte write sets compare enable.
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module cam_top
  import cam_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic                        clock_i,
  input  wire logic                        rst_b_i,
  input  wire logic [ADDR_W-1:0]           paddr_i,
  input  wire logic                        psel_i,
  input  wire logic                        penable_i,
  input  wire logic                        pwrite_i,
  input  wire logic [31:0]                 pwdata_i,
  output logic      [31:0]                 prdata_o,
  output logic                             pready_o,
  output logic                             pslverr_o,
  input  wire logic [cam_pkg::NUM_MOD-1:0] module_input_pin_i,
  output wire logic [cam_pkg::NUM_MOD-1:0] module_output_pin_o,
  output logic                             irq_o,
  output logic                             watchdog_reset_o
);
  logic [NUM_MOD-1:0][7:0]       mode_r;
  logic [NUM_MOD-1:0][7:0]       mode_nxt;
  logic [7:0]                    cfg_r;
  logic [7:0]                    cfg_nxt;
  logic [7:0]                    ctl_r;
  logic [7:0]                    ctl_nxt;
  logic                          cov_flag_r;
  logic                          cov_flag_nxt;
  logic                          cnt_flag_r;
  logic                          cnt_flag_nxt;
  logic [NUM_MOD-1:0]            ccf_r;
  logic [NUM_MOD-1:0]            ccf_nxt;
  logic [CNT_W-1:0]              count_r;
  logic [CNT_W-1:0]              count_nxt;
  logic                          tick_r;
  logic [31:0]                   prdata_nxt;
  logic                          pready_nxt;
  logic                          pslverr_nxt;
  logic                          irq_nxt;
  logic                          wdog_nxt;
  logic [IDX_W-1:0]              idx;
  logic                          setup;
  logic                          wr;
  logic                          hit;
  logic                          stat_wr;
  logic                          cfg_wr;
  logic [31:0]                   rd;
  logic [NUM_MOD-1:0]            wr_lo;
  logic [NUM_MOD-1:0]            wr_hi;
  logic [NUM_MOD-1:0]            ccf_set;
  logic [NUM_MOD-1:0]            pin_sync;
  logic [NUM_MOD-1:0][CNT_W-1:0] cap_val;
  logic [NUM_MOD-1:0][CNT_W-1:0] rld_val;
  logic [4:0]                    len_bits;
  logic [CNT_W-1:0]              cycle_mask;
  logic                          cycle_wrap;
  logic                          count_wrap;

  cam_sync #(
    .WIDTH (NUM_MOD)
  ) u_pin_sync (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .async_i (module_input_pin_i),
    .sync_o  (pin_sync)
  );

  genvar g;
  generate
    for (g = 0; g < NUM_MOD; g++) begin : g_mod
      cam_channel u_channel (
        .clock_i             (clock_i),
        .rst_b_i             (rst_b_i),
        .mode_i              (mode_r[g]),
        .count_i             (count_r),
        .tick_i              (tick_r),
        .cycle_mask_i        (cycle_mask),
        .cycle_wrap_i        (cycle_wrap),
        .count_wrap_i        (count_wrap),
        .autoreload_en_i     (cfg_r[CB_AR]),
        .pin_sync_i          (pin_sync[g]),
        .wr_lo_i             (wr_lo[g]),
        .wr_hi_i             (wr_hi[g]),
        .bank_sel_i          (cfg_r[CB_BANK]),
        .wdata_i             (pwdata_i[BYTE_W-1:0]),
        .capture_value_o     (cap_val[g]),
        .reload_value_o      (rld_val[g]),
        .module_output_pin_o (module_output_pin_o[g]),
        .flag_set_o          (ccf_set[g])
      );
    end
  endgenerate

  // Main counter and the wrap events of the full and the selected cycle.
  always_comb begin
    len_bits   = PWM_MIN_LEN + 5'(cfg_r[LEN_W-1:0]);
    cycle_mask = ~(CNT_ONES << len_bits);
    count_wrap = ctl_r[CT_RUN] && (count_r == CNT_ONES);
    cycle_wrap = ctl_r[CT_RUN] && ((count_r & cycle_mask) == cycle_mask);
    count_nxt  = ctl_r[CT_RUN] ? count_r + 16'h0001 : count_r;
  end

  // Register decode; unmapped indices answer with an error and no effect.
  always_comb begin
    if (paddr_i[ADDR_W-1:IDX_W+2] == '0) begin
      idx = paddr_i[IDX_W+1:2];
    end else begin
      idx = IDX_NONE;
    end
    setup    = psel_i && !penable_i;
    wr       = psel_i && penable_i && pready_o && pwrite_i;
    rd       = '0;
    hit      = 1'b0;
    stat_wr  = 1'b0;
    cfg_wr   = 1'b0;
    wr_lo    = '0;
    wr_hi    = '0;
    mode_nxt = mode_r;
    cfg_nxt  = cfg_r;
    ctl_nxt  = ctl_r;
    if (idx == IDX_STATUS) begin
      hit                 = 1'b1;
      rd[SB_CNT_OVF]      = cnt_flag_r;
      rd[NUM_MOD-1:0]     = ccf_r;
      stat_wr             = wr;
    end
    if (idx == IDX_CONTROL) begin
      hit       = 1'b1;
      rd[7:0]   = ctl_r;
      if (wr) begin
        if (ctl_r[CT_WDOG]) begin
          ctl_nxt[CT_WDOG] = pwdata_i[CT_WDOG];
        end else begin
          ctl_nxt = pwdata_i[7:0] & CTL_WMASK;
        end
      end
    end
    if (idx == IDX_CONFIG) begin
      hit             = 1'b1;
      rd[7:0]         = cfg_r;
      rd[CB_COV_FLAG] = cov_flag_r;
      cfg_wr          = wr;
      if (wr) begin
        cfg_nxt = pwdata_i[7:0] & CFG_WMASK;
      end
    end
    if (idx == IDX_CNT_LO) begin
      hit     = 1'b1;
      rd[7:0] = count_r[BYTE_W-1:0];
    end
    if (idx == IDX_CNT_HI) begin
      hit     = 1'b1;
      rd[7:0] = count_r[CNT_W-1:BYTE_W];
    end
    for (int n = 0; n < NUM_MOD; n++) begin
      if (idx == IDX_MODE[n]) begin
        hit     = 1'b1;
        rd[7:0] = mode_r[n];
        if (wr && !(n == WDOG_MOD && ctl_r[CT_WDOG])) begin
          mode_nxt[n] = pwdata_i[7:0];
        end
      end
      if (idx == IDX_CPL[n]) begin
        hit      = 1'b1;
        rd[7:0]  = cfg_r[CB_BANK] ? rld_val[n][BYTE_W-1:0] : cap_val[n][BYTE_W-1:0];
        wr_lo[n] = wr;
        if (wr && !(n == WDOG_MOD && ctl_r[CT_WDOG])) begin
          mode_nxt[n][MB_CMP] = 1'b0;
        end
      end
      if (idx == IDX_CPH[n]) begin
        hit      = 1'b1;
        rd[7:0]  = cfg_r[CB_BANK] ? rld_val[n][CNT_W-1:BYTE_W] : cap_val[n][CNT_W-1:BYTE_W];
        wr_hi[n] = wr;
        if (wr && !(n == WDOG_MOD && ctl_r[CT_WDOG])) begin
          mode_nxt[n][MB_CMP] = 1'b1;
        end
      end
    end
    if (!hit) begin
      wr_lo    = '0;
      wr_hi    = '0;
    end
    pready_nxt  = setup;
    pslverr_nxt = setup && !hit;
    prdata_nxt  = setup ? rd : prdata_o;
  end

  // Flags: a hardware set in the same cycle as a software clear wins.
  always_comb begin
    cnt_flag_nxt = count_wrap || (stat_wr ? pwdata_i[SB_CNT_OVF] : cnt_flag_r);
    ccf_nxt      = ccf_set | (stat_wr ? pwdata_i[NUM_MOD-1:0] : ccf_r);
    cov_flag_nxt = cycle_wrap || (cfg_wr ? pwdata_i[CB_COV_FLAG] : cov_flag_r);
    irq_nxt      = 1'b0;
    for (int n = 0; n < NUM_MOD; n++) begin
      if (ccf_r[n] && mode_r[n][MB_IRQ]) begin
        irq_nxt = 1'b1;
      end
    end
    if (cov_flag_r && cfg_r[CB_COV_IRQ]) begin
      irq_nxt = 1'b1;
    end
    if (cnt_flag_r && ctl_r[CT_CNT_IRQ]) begin
      irq_nxt = 1'b1;
    end
    // Module 2 as watchdog fires when the counter high byte meets its value.
    wdog_nxt = ctl_r[CT_WDOG] && tick_r
               && (count_r[CNT_W-1:BYTE_W] == cap_val[WDOG_MOD][CNT_W-1:BYTE_W]);
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_r           <= {NUM_MOD{MODE_RST}};
      cfg_r            <= CFG_RST;
      ctl_r            <= CTL_RST;
      cov_flag_r       <= 1'b0;
      cnt_flag_r       <= 1'b0;
      ccf_r            <= '0;
      count_r          <= '0;
      tick_r           <= 1'b0;
      prdata_o         <= '0;
      pready_o         <= 1'b0;
      pslverr_o        <= 1'b0;
      irq_o            <= 1'b0;
      watchdog_reset_o <= 1'b0;
    end else begin
      mode_r           <= mode_nxt;
      cfg_r            <= cfg_nxt;
      ctl_r            <= ctl_nxt;
      cov_flag_r       <= cov_flag_nxt;
      cnt_flag_r       <= cnt_flag_nxt;
      ccf_r            <= ccf_nxt;
      count_r          <= count_nxt;
      tick_r           <= ctl_r[CT_RUN];
      prdata_o         <= prdata_nxt;
      pready_o         <= pready_nxt;
      pslverr_o        <= pslverr_nxt;
      irq_o            <= irq_nxt;
      watchdog_reset_o <= wdog_nxt;
    end
  end
endmodule
`default_nettype wire

// *** cam_pkg.sv ***
// Constants and types shared by the counter array capture/compare files.
package cam_pkg;
  localparam int          CNT_W       = 16;
  localparam int          BYTE_W      = 8;
  localparam int          NUM_MOD     = 3;
  localparam int          IDX_W       = 8;
  localparam int          LEN_W       = 3;
  localparam int          WDOG_MOD    = 2;
  localparam logic [4:0]  PWM_MIN_LEN = 5'h08;
  // Register word indices; byte address is four times the index.
  localparam logic [7:0]  IDX_NONE    = 8'h00;
  localparam logic [7:0]  IDX_STATUS  = 8'hD8;
  localparam logic [7:0]  IDX_CONTROL = 8'hD9;
  localparam logic [7:0]  IDX_CONFIG  = 8'hF7;
  localparam logic [7:0]  IDX_CNT_LO  = 8'hF9;
  localparam logic [7:0]  IDX_CNT_HI  = 8'hFA;
  localparam logic [7:0]  IDX_MODE [NUM_MOD] = '{8'hDA, 8'hDB, 8'hDC};
  localparam logic [7:0]  IDX_CPL  [NUM_MOD] = '{8'hFB, 8'hE9, 8'hEB};
  localparam logic [7:0]  IDX_CPH  [NUM_MOD] = '{8'hFC, 8'hEA, 8'hEC};
  // Mode register fields.
  localparam int          MB_WIDE     = 7;
  localparam int          MB_CMP      = 6;
  localparam int          MB_RISE     = 5;
  localparam int          MB_FALL     = 4;
  localparam int          MB_MATCH    = 3;
  localparam int          MB_TOG      = 2;
  localparam int          MB_PWM      = 1;
  localparam int          MB_IRQ      = 0;
  // Configuration register fields.
  localparam int          CB_BANK     = 7;
  localparam int          CB_COV_IRQ  = 6;
  localparam int          CB_COV_FLAG = 5;
  localparam int          CB_AR       = 3;
  localparam logic [7:0]  CFG_WMASK   = 8'hCF;
  // Control and status register fields.
  localparam int          CT_RUN      = 0;
  localparam int          CT_CNT_IRQ  = 1;
  localparam int          CT_WDOG     = 6;
  localparam logic [7:0]  CTL_WMASK   = 8'h43;
  localparam int          SB_CNT_OVF  = 7;
  localparam logic [7:0]  MODE_RST    = 8'h00;
  localparam logic [7:0]  CFG_RST     = 8'h00;
  localparam logic [7:0]  CTL_RST     = 8'h00;
  localparam logic [15:0] CNT_ONES    = 16'hFFFF;

  typedef enum logic [2:0] {
    CAM_IDLE,
    CAM_TOGGLE,
    CAM_FREQ,
    CAM_PWM_N,
    CAM_PWM_W
  } cam_func_t;
endpackage

// *** cam_sync.sv ***
// Two flip-flop synchroniser for the module input pins.
`timescale 1ns/1ns
`default_nettype none
module cam_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock_i,
  input  wire logic             rst_b_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule
`default_nettype wire

// *** cam_channel.sv ***
// One capture/compare module: capture, match, toggle, frequency and PWM output.
`timescale 1ns/1ns
`default_nettype none
module cam_channel
  import cam_pkg::*;
(
  input  wire logic                       clock_i,
  input  wire logic                       rst_b_i,
  input  wire logic [7:0]                 mode_i,
  input  wire logic [cam_pkg::CNT_W-1:0]  count_i,
  input  wire logic                       tick_i,
  input  wire logic [cam_pkg::CNT_W-1:0]  cycle_mask_i,
  input  wire logic                       cycle_wrap_i,
  input  wire logic                       count_wrap_i,
  input  wire logic                       autoreload_en_i,
  input  wire logic                       pin_sync_i,
  input  wire logic                       wr_lo_i,
  input  wire logic                       wr_hi_i,
  input  wire logic                       bank_sel_i,
  input  wire logic [cam_pkg::BYTE_W-1:0] wdata_i,
  output logic      [cam_pkg::CNT_W-1:0]  capture_value_o,
  output logic      [cam_pkg::CNT_W-1:0]  reload_value_o,
  output logic                            module_output_pin_o,
  output logic                            flag_set_o
);
  logic [CNT_W-1:0] cmp_nxt;
  logic [CNT_W-1:0] rld_nxt;
  logic             out_nxt;
  logic             pin_d_r;
  logic             full_match;
  logic             low_match;
  cam_func_t        func;

  always_comb begin
    if (mode_i[MB_PWM] && mode_i[MB_TOG]) begin
      func = CAM_FREQ;
    end else if (mode_i[MB_PWM]) begin
      func = mode_i[MB_WIDE] ? CAM_PWM_W : CAM_PWM_N;
    end else if (mode_i[MB_TOG]) begin
      func = CAM_TOGGLE;
    end else begin
      func = CAM_IDLE;
    end
    full_match = tick_i && (count_i == capture_value_o);
    low_match  = tick_i && (count_i[BYTE_W-1:0] == capture_value_o[BYTE_W-1:0]);
    cmp_nxt    = capture_value_o;
    rld_nxt    = reload_value_o;
    out_nxt    = module_output_pin_o;
    flag_set_o = 1'b0;
    if ((mode_i[MB_RISE] && pin_sync_i && !pin_d_r) ||
        (mode_i[MB_FALL] && !pin_sync_i && pin_d_r)) begin
      cmp_nxt    = count_i;
      flag_set_o = 1'b1;
    end
    if (mode_i[MB_CMP]) begin
      unique case (func)
        CAM_TOGGLE: begin
          if (full_match) begin
            out_nxt = !module_output_pin_o;
          end
        end
        CAM_FREQ: begin
          if (low_match) begin
            out_nxt = !module_output_pin_o;
            cmp_nxt[BYTE_W-1:0] = capture_value_o[BYTE_W-1:0]
                                + capture_value_o[CNT_W-1:BYTE_W];
          end
        end
        CAM_PWM_N: begin
          // The width follows the cycle length; reload lands at each cycle end.
          out_nxt = (count_i & cycle_mask_i) >= (capture_value_o & cycle_mask_i);
          if (cycle_wrap_i) begin
            cmp_nxt = reload_value_o;
          end
        end
        CAM_PWM_W: begin
          out_nxt = count_i >= capture_value_o;
          if (count_wrap_i && autoreload_en_i) begin
            cmp_nxt = reload_value_o;
          end
        end
        CAM_IDLE: begin
        end
      endcase
      if (mode_i[MB_MATCH] && full_match) begin
        flag_set_o = 1'b1;
      end
    end
    if (wr_lo_i) begin
      if (bank_sel_i) begin
        rld_nxt[BYTE_W-1:0] = wdata_i;
      end else begin
        cmp_nxt[BYTE_W-1:0] = wdata_i;
      end
    end
    if (wr_hi_i) begin
      if (bank_sel_i) begin
        rld_nxt[CNT_W-1:BYTE_W] = wdata_i;
      end else begin
        cmp_nxt[CNT_W-1:BYTE_W] = wdata_i;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      capture_value_o     <= '0;
      reload_value_o      <= '0;
      module_output_pin_o <= 1'b0;
      pin_d_r             <= 1'b0;
    end else begin
      capture_value_o     <= cmp_nxt;
      reload_value_o      <= rld_nxt;
      module_output_pin_o <= out_nxt;
      pin_d_r             <= pin_sync_i;
    end
  end
endmodule
`default_nettype wire

// *** cam_top_chk.sv ***
// Checker that watches the counter array top ports.
`timescale 1ns/1ns
`default_nettype none
module cam_top_chk
  import cam_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic                        clock_i,
  input  wire logic                        rst_b_i,
  input  wire logic [ADDR_W-1:0]           paddr_i,
  input  wire logic                        psel_i,
  input  wire logic                        penable_i,
  input  wire logic                        pwrite_i,
  input  wire logic [31:0]                 pwdata_i,
  input  wire logic [31:0]                 prdata_o,
  input  wire logic                        pready_o,
  input  wire logic                        pslverr_o,
  input  wire logic [cam_pkg::NUM_MOD-1:0] module_input_pin_i,
  input  wire logic [cam_pkg::NUM_MOD-1:0] module_output_pin_o,
  input  wire logic                        irq_o,
  input  wire logic                        watchdog_reset_o
);
  import cam_pkg::*;
  logic hi_ok;
  assign hi_ok = paddr_i[ADDR_W-1:10] == '0;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  sequence setup_s;
    psel_i && !penable_i;
  endsequence
  sequence access_s;
    psel_i && penable_i && pready_o;
  endsequence
  sequence read_s;
    access_s ##0 !pwrite_i;
  endsequence
  setup_ready_a: assert property (setup_s |=> access_s)
    else $error("no access cycle after setup");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready held longer than one cycle");
  err_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  unmapped_err_a: assert property (read_s ##0 !hi_ok |-> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped read not refused");
  upper_zero_a: assert property (read_s |-> prdata_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  cfg_bit_four_a: assert property (
    read_s ##0 (hi_ok && paddr_i[9:2] == IDX_CONFIG) |-> !prdata_o[4])
    else $error("unused configuration bit reads one");
  mode_ok_a: assert property (access_s ##0 (hi_ok && paddr_i[9:2] == IDX_MODE[0]) |-> !pslverr_o)
    else $error("mode access refused");
  reset_quiet_a: assert property (
    $rose(rst_b_i) |-> !irq_o && module_output_pin_o == '0 && !watchdog_reset_o)
    else $error("outputs active after reset");
endmodule
`default_nettype wire

// *** cam_pins.sv ***
// Model of the external sources that drive the module input pins.
`timescale 1ns/1ns
`default_nettype none
module cam_pins
  import cam_pkg::*;
(
  input  wire logic                        clock_i,
  input  wire logic [cam_pkg::NUM_MOD-1:0] module_output_pin_i,
  output logic      [cam_pkg::NUM_MOD-1:0] module_input_pin_o
);
  import cam_pkg::*;
  initial module_input_pin_o = '0;
  // Levels change just after a rising edge, as a synchronous source would.
  task automatic set_pin(input int ch, input logic v);
    @(posedge clock_i);
    module_input_pin_o[ch] <= v;
  endtask
endmodule
`default_nettype wire

// *** counter_array_module_modes_bench.sv ***
// Self-checking bench for the counter array capture/compare block.
`timescale 1ns/1ns
`default_nettype none
module counter_array_module_modes_bench;
  import cam_pkg::*;
  logic                clk;
  logic                rst_b;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [11:0]         paddr;
  logic [31:0]         pwdata;
  wire  [31:0]         prdata;
  wire                 pready;
  wire                 pslverr;
  wire                 irq;
  wire                 wdog;
  wire  [NUM_MOD-1:0]  pin_in;
  wire  [NUM_MOD-1:0]  pin_out;
  int                  errors;
  int                  checks_done;
  int                  hi;
  int                  ed;
  logic [31:0]         r;
  logic                e;
  logic [15:0]         cnt;

  cam_top i_dut (.clock_i(clk), .rst_b_i(rst_b), .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .module_input_pin_i(pin_in),
    .module_output_pin_o(pin_out), .irq_o(irq), .watchdog_reset_o(wdog));
  cam_pins i_pins (.clock_i(clk), .module_output_pin_i(pin_out), .module_input_pin_o(pin_in));

  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    // Look at the settled answer in mid-cycle; the request stands until the next rising edge.
    @(negedge clk);
    while (pready !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    if (n >= 50) begin
      errors++;
      $display("BAD %0t no ready from the register bus", $time);
    end
    r = prdata;
    e = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, ba(idx), d);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, ba(idx), 8'h00);
    chk(r, exp);
  endtask
  task automatic rd_cnt;
    apb(1'b0, ba(IDX_CNT_LO), 8'h00);
    cnt[7:0] = r[7:0];
    apb(1'b0, ba(IDX_CNT_HI), 8'h00);
    cnt[15:8] = r[7:0];
  endtask
  task automatic measure(input int ch);
    logic p;
    hi = 0;
    ed = 0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    p = pin_out[ch];
    repeat (512) begin
      @(negedge clk);
      hi += int'(pin_out[ch] === 1'b1);
      ed += int'(pin_out[ch] !== p);
      p = pin_out[ch];
    end
  endtask

  task automatic t_reset;
    for (int i = 0; i < NUM_MOD; i++)
      rdc(IDX_MODE[i], 32'h0);
    rdc(IDX_CONFIG, 32'h0);
    chk(32'(irq), 32'h0);
    $display("reset test done");
  endtask
  task automatic t_cycle;
    wr(IDX_CONFIG, 8'h41);
    wr(IDX_CONTROL, 8'h01);
    repeat (400) @(posedge clk);
    rdc(IDX_CONFIG, 32'h41);
    chk(32'(irq), 32'h0);
    repeat (200) @(posedge clk);
    rdc(IDX_CONFIG, 32'h61);
    chk(32'(irq), 32'h1);
    repeat (600) @(posedge clk);
    rdc(IDX_CONFIG, 32'h61);
    wr(IDX_CONTROL, 8'h00);
    wr(IDX_CONFIG, 8'h41);
    rdc(IDX_CONFIG, 32'h41);
    chk(32'(irq), 32'h0);
    wr(IDX_CONFIG, 8'h21);
    rdc(IDX_CONFIG, 32'h21);
    chk(32'(irq), 32'h0);
    wr(IDX_CONFIG, 8'h17);
    rdc(IDX_CONFIG, 32'h07);
    wr(IDX_CONFIG, 8'h00);
    $display("cycle flag test done");
  endtask
  task automatic t_capture;
    rd_cnt();
    wr(IDX_MODE[0], 8'h20);
    wr(IDX_MODE[1], 8'h10);
    i_pins.set_pin(0, 1'b1);
    i_pins.set_pin(1, 1'b1);
    repeat (8) @(posedge clk);
    rdc(IDX_CPL[1], 32'h0);
    rdc(IDX_CPL[0], 32'(cnt[7:0]));
    rdc(IDX_CPH[0], 32'(cnt[15:8]));
    i_pins.set_pin(1, 1'b0);
    repeat (8) @(posedge clk);
    rdc(IDX_CPL[1], 32'(cnt[7:0]));
    rdc(IDX_CPH[1], 32'(cnt[15:8]));
    $display("capture test done");
  endtask
  task automatic t_match;
    logic [15:0] v;
    int          n;
    rd_cnt();
    v = cnt + 16'h0100;
    n = 0;
    wr(IDX_STATUS, 8'h00);
    wr(IDX_MODE[0], 8'h4D);
    wr(IDX_CPL[0], v[7:0]);
    rdc(IDX_MODE[0], 32'h0D);
    wr(IDX_CPH[0], v[15:8]);
    rdc(IDX_MODE[0], 32'h4D);
    chk(32'(pin_out[0]), 32'h0);
    wr(IDX_CONTROL, 8'h01);
    while (irq !== 1'b1 && n < 600) begin
      @(posedge clk);
      n++;
    end
    rdc(IDX_STATUS, 32'h01);
    chk(32'(pin_out[0]), 32'h1);
    chk(32'(irq), 32'h1);
    wr(IDX_CONTROL, 8'h00);
    wr(IDX_MODE[0], 8'h4C);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    wr(IDX_STATUS, 8'h00);
    $display("match test done");
  endtask
  task automatic t_pwm;
    wr(IDX_CONFIG, 8'h80);
    wr(IDX_CPL[1], 8'hC0);
    wr(IDX_CPH[1], 8'hFF);
    rdc(IDX_CPL[1], 32'hC0);
    wr(IDX_CONFIG, 8'h00);
    wr(IDX_CPL[1], 8'hC0);
    wr(IDX_CPH[1], 8'hFF);
    wr(IDX_MODE[1], 8'h42);
    wr(IDX_CONTROL, 8'h01);
    measure(1);
    chk(32'(hi), 32'd128);
    wr(IDX_CONFIG, 8'h01);
    measure(1);
    chk(32'(hi), 32'd64);
    wr(IDX_MODE[1], 8'hC2);
    measure(1);
    chk(32'(hi), 32'd0);
    wr(IDX_CPL[1], 8'h00);
    wr(IDX_CPH[1], 8'h10);
    wr(IDX_MODE[1], 8'h46);
    repeat (300) @(posedge clk);
    measure(1);
    chk(32'(ed), 32'd32);
    $display("pwm test done");
  endtask
  task automatic t_wdog;
    wr(IDX_CONTROL, 8'h41);
    wr(IDX_MODE[2], 8'h42);
    rdc(IDX_MODE[2], 32'h0);
    wr(IDX_CONTROL, 8'h00);
    wr(IDX_MODE[2], 8'h42);
    rdc(IDX_MODE[2], 32'h42);
    wr(IDX_MODE[2], 8'h00);
    apb(1'b1, 12'h400, 8'hFF);
    chk(32'(e), 32'h1);
    apb(1'b0, 12'h400, 8'h00);
    chk(r, 32'h0);
    chk(32'(e), 32'h1);
    $display("watchdog and unmapped test done");
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    give_verdict();
  end
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    errors = 0;
    checks_done = 0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_cycle();
    t_capture();
    t_match();
    t_pwm();
    t_wdog();
    give_verdict();
  end
endmodule

bind cam_top cam_top_chk #(.ADDR_W(ADDR_W)) i_chk (.clock_i(clock_i), .rst_b_i(rst_b_i),
  .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .module_input_pin_i(module_input_pin_i), .module_output_pin_o(module_output_pin_o),
  .irq_o(irq_o), .watchdog_reset_o(watchdog_reset_o));
`default_nettype wire
